/* verif/sfpi_core_tb_top.sv */
// self-checking bench for the serial flash pin front end
module sfpi_core_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int DLY = 5;
	logic       sys_clk_in, rst_in, sclk, cs_n, mosi, qe, pmh, pml, hsel, busy, rx_ready, tx_valid;
	logic       wp_en, wp_val, hold_val, so_last, rx_valid, tx_ready, standby, swb, hold_act, hw_rst, ovr;
	logic [1:0] lane_mode;
	logic [7:0] tx_data, rx_data, q, n_take;
	logic [3:0] io_in, io_out, io_oe_n;
	int         n_errors, cmp_count, cycles;
	// device drive wins; lane two pulls up unless wp_en, lane three follows hold_val
	assign io_in[0] = !io_oe_n[0] ? io_out[0] : mosi;
	assign io_in[1] = io_oe_n[1] ? ~so_last : io_out[1];
	assign io_in[2] = !io_oe_n[2] ? io_out[2] : (wp_en ? wp_val : 1'b1);
	assign io_in[3] = !io_oe_n[3] ? io_out[3] : hold_val;
	sfpi_host_model sfpi_host_model_i (.sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi), .miso_in(io_in[1]));
	sfpi_core sfpi_core_i (
		.sys_clk_in(sys_clk_in), .rst_in(rst_in), .sclk_in(sclk), .cs_n_in(cs_n), .io_in(io_in),
		.io_out(io_out), .io_oe_n_out(io_oe_n), .quad_lane_enable_in(qe), .protect_mode_high_in(pmh),
		.protect_mode_low_in(pml), .hold_select_in(hsel), .lane_mode_in(lane_mode), .op_busy_in(busy),
		.rx_valid_out(rx_valid), .rx_ready_in(rx_ready), .rx_data_out(rx_data), .tx_valid_in(tx_valid),
		.tx_ready_out(tx_ready), .tx_data_in(tx_data), .standby_out(standby),
		.status_write_block_out(swb), .hold_active_out(hold_act), .hw_reset_out(hw_rst),
		.rx_overrun_out(ovr));
	initial begin
		sys_clk_in = 1'b0;
		forever #25 sys_clk_in = ~sys_clk_in;
	end
	// byte handed over ends the offer; hang guard
	always @(posedge sys_clk_in) begin
		if (!io_oe_n[1]) so_last <= io_out[1];
		if (tx_ready === 1'b1) begin
			tx_valid <= 1'b0;
			n_take <= n_take + 8'h01;
		end
		cycles++;
		if (cycles == 6000) begin
			n_errors++;
			$display("CHECK FAILED at %0t: timeout", $time);
			end_sim();
		end
	end
	task automatic chk_bit(input logic g, input logic e, input string m);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask
	task automatic chk_byte(input logic [7:0] g, input logic [7:0] e, input string m);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask
	task automatic chk_nib(input logic [3:0] g, input logic [3:0] e, input string m);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_in);
		#DLY;
	endtask
	// bounded wait for a received byte, then accept it
	task automatic wait_rx(input logic [7:0] e);
		int k;
		k = 0;
		while (rx_valid !== 1'b1 && k < 50) begin
			tick(1);
			k++;
		end
		chk_byte(rx_data, e, "rx byte");
		rx_ready = 1'b1;
		tick(1);
		rx_ready = 1'b0;
		// one idle edge so a following accept never rewrites ready in the same step
		tick(1);
	endtask
	// protect pin settings against the block flag
	task automatic prot(input logic q_e, h, l, en, v, e);
		qe = q_e;
		pmh = h;
		pml = l;
		wp_en = en;
		wp_val = v;
		tick(5);
		chk_bit(swb, e, "status write block");
	endtask
	// mode 3 frame with no command: the first falling edge is the byte boundary
	task automatic wide(input logic [1:0] mode, input logic [7:0] d, qx, input logic [3:0] oe, input int nb);
		lane_mode = mode;
		qe = mode[1];
		sfpi_host_model_i.select(1'b1);
		tx_data = d;
		tx_valid = 1'b1;
		sfpi_host_model_i.xfer(8'h00, q);
		chk_byte(q, qx, "wide tx lane one");
		chk_nib(io_oe_n, oe, "wide drive");
		sfpi_host_model_i.deselect();
		wait_rx(d);
		for (int i = 1; i < nb; i++)
			wait_rx(8'h00);
		lane_mode = 2'h0;
		qe = 1'b0;
	endtask
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		{qe, pmh, pml, hsel, busy, rx_ready, tx_valid, wp_en, wp_val, so_last} = '0;
		hold_val = 1'b1;
		lane_mode = 2'h0;
		tx_data = 8'h00;
		n_take = 8'h00;
		n_errors = 0;
		cmp_count = 0;
		cycles = 0;
		rst_in = 1'b1;
		tick(5);
		rst_in = 1'b0;
		tick(4);
		// deselected: pins released, clocking ignored, standby unless busy
		chk_nib(io_oe_n, 4'hf, "released");
		chk_bit(standby, 1'b1, "standby");
		sfpi_host_model_i.xfer(8'hff, q);
		sfpi_host_model_i.deselect();
		tick(4);
		chk_bit(rx_valid, 1'b0, "ignored");
		busy = 1'b1;
		tick(4);
		chk_bit(standby, 1'b0, "busy");
		busy = 1'b0;
		tick(4);
		chk_bit(standby, 1'b1, "standby back");
		$display("test deselect done");
		// command in, answer out, clock modes 0 and 3
		for (int m = 0; m < 2; m++) begin
			sfpi_host_model_i.select(m[0]);
			sfpi_host_model_i.xfer(8'ha5 ^ m[7:0], q);
			chk_bit(standby, 1'b0, "selected");
			tick(1);
			tx_data = 8'h3c ^ m[7:0];
			tx_valid = 1'b1;
			sfpi_host_model_i.xfer(8'h00, q);
			chk_byte(q, 8'h3c ^ m[7:0], "tx byte");
			sfpi_host_model_i.deselect();
			wait_rx(8'ha5 ^ m[7:0]);
			wait_rx(8'h00);
			tick(4);
			chk_nib(io_oe_n, 4'hf, "released after");
		end
		$display("test transfer done");
		// dual and quad answers read back on lane one and through the receive side
		wide(2'h1, 8'hb4, 8'hc0, 4'hc, 2);
		wide(2'h2, 8'h69, 8'h80, 4'h0, 4);
		chk_byte(n_take, 8'h04, "tx takes");
		$display("test lanes done");
		prot(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
		prot(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
		prot(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
		prot(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
		prot(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
		wp_en = 1'b0;
		qe = 1'b0;
		$display("test protect done");
		// hold or reset from the same pin
		hsel = 1'b1;
		hold_val = 1'b0;
		tick(5);
		chk_bit(hw_rst, 1'b1, "hw reset");
		hsel = 1'b0;
		sfpi_host_model_i.select(1'b0);
		tick(5);
		chk_bit(hold_act, 1'b1, "hold");
		chk_bit(hw_rst, 1'b0, "no reset");
		hold_val = 1'b1;
		sfpi_host_model_i.deselect();
		$display("test hold done");
		// fill past the fifo depth, then drain in order
		chk_bit(ovr, 1'b0, "no overrun yet");
		sfpi_host_model_i.select(1'b0);
		for (int i = 0; i < 6; i++)
			sfpi_host_model_i.xfer(8'h10 + i[7:0], q);
		sfpi_host_model_i.deselect();
		tick(4);
		chk_bit(ovr, 1'b1, "overrun");
		for (int i = 0; i < 4; i++)
			wait_rx(8'h10 + i[7:0]);
		$display("test fifo done");
		end_sim();
	end
endmodule

/* verif/sfpi_host_model.sv */
// spi host model that drives clock, select and serial input
module sfpi_host_model (
	// pins toward the device
	output logic      sclk_out,
	output logic      cs_n_out,
	output logic      mosi_out,
	input  wire logic miso_in
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int HALF = 200;
	logic cpol;
	// clock stands still and select is high outside frames
	initial begin
		cpol = 1'b0;
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		mosi_out = 1'b0;
	end
	// select with the clock idling low or high
	task automatic select(input logic idle_high);
		cpol = idle_high;
		sclk_out = idle_high;
		#HALF cs_n_out = 1'b0;
		#HALF;
	endtask
	// one byte msb first: change on falling, sample on rising
	task automatic xfer(input logic [7:0] d, output logic [7:0] q);
		for (int i = 7; i >= 0; i--) begin
			sclk_out = 1'b0;
			mosi_out = d[i];
			#HALF sclk_out = 1'b1;
			q[i] = miso_in;
			#HALF;
		end
	endtask
	// released line shows the inverse, not the stale bit
	task automatic deselect();
		sclk_out = cpol;
		#HALF cs_n_out = 1'b1;
		mosi_out = ~mosi_out;
		#HALF;
	endtask
endmodule

/* verilog/sfpi_core.sv */
// pin-level front end of the serial flash spi port
`include "sfpi_defines.svh"
module sfpi_core
	import sfpi_pkg::*;
(
	// clock and reset
	input  wire logic                    sys_clk_in,
	input  wire logic                    rst_in,
	// spi pins, raw from outside
	input  wire logic                    sclk_in,
	input  wire logic                    cs_n_in,
	input  wire logic [3:0]              io_in,
	output logic [3:0]                   io_out,
	output logic [3:0]                   io_oe_n_out,
	// configuration bits
	input  wire logic                    quad_lane_enable_in,
	input  wire logic                    protect_mode_high_in,
	input  wire logic                    protect_mode_low_in,
	input  wire logic                    hold_select_in,
	input  wire logic [1:0]              lane_mode_in,
	// internal operation status
	input  wire logic                    op_busy_in,
	// received bytes toward the command logic
	output logic                         rx_valid_out,
	input  wire logic                    rx_ready_in,
	output logic [`SFPI_BYTE_W-1:0]      rx_data_out,
	// bytes to send toward the host
	input  wire logic                    tx_valid_in,
	output logic                         tx_ready_out,
	input  wire logic [`SFPI_BYTE_W-1:0] tx_data_in,
	// status outputs
	output logic                         standby_out,
	output logic                         status_write_block_out,
	output logic                         hold_active_out,
	output logic                         hw_reset_out,
	output logic                         rx_overrun_out
);
	// ----------------------------------------
	// synchronisers
	// ----------------------------------------
	logic [5:0] s1_reg, s2_reg, s3_reg;
	logic [5:0] s1_next;

	// io[2] and io[3] pins idle high via pull-up; reset value is high
	always_comb begin
		s1_next = {io_in, cs_n_in, sclk_in};
	end
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			s1_reg <= 6'h3e;
			s2_reg <= 6'h3e;
			s3_reg <= 6'h3e;
		end else begin
			s1_reg <= s1_next;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	logic sclk_s, cs_n_s, sclk_rise, sclk_fall, selected;
	logic [3:0] io_s;
	assign sclk_s    = s2_reg[0];
	assign cs_n_s    = s2_reg[1];
	assign io_s      = s2_reg[5:2];
	assign selected  = !cs_n_s;
	// edges from stages two and three; works for either idle level
	assign sclk_rise = selected && sclk_s && !s3_reg[0];
	assign sclk_fall = selected && !sclk_s && s3_reg[0];

	// ----------------------------------------
	// power state
	// ----------------------------------------
	sfpi_state_t st_reg, st_next;
	always_comb begin
		st_next = st_reg;
		unique case (st_reg)
			SFPI_ST_STANDBY: begin
				if (selected)
					st_next = SFPI_ST_ACTIVE;
				else if (op_busy_in)
					st_next = SFPI_ST_BUSY;
			end
			SFPI_ST_BUSY: begin
				if (selected)
					st_next = SFPI_ST_ACTIVE;
				else if (!op_busy_in)
					st_next = SFPI_ST_STANDBY;
			end
			SFPI_ST_ACTIVE: begin
				if (!selected)
					st_next = op_busy_in ? SFPI_ST_BUSY : SFPI_ST_STANDBY;
			end
		endcase
	end
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in)
			st_reg <= SFPI_ST_STANDBY;
		else
			st_reg <= st_next;
	end
	assign standby_out = (st_reg == SFPI_ST_STANDBY);

	// ----------------------------------------
	// pin roles
	// ----------------------------------------
	logic quad_ok, lane2_is_data, hold_pin_raw;
	assign quad_ok       = quad_lane_enable_in;
	assign lane2_is_data = quad_ok;
	assign hold_pin_raw  = io_s[3];
	// protect pin only counts with lane enable clear and mode 0/1
	assign status_write_block_out = !quad_ok && (protect_mode_high_in == `SFPI_PMODE_HIGH)
		&& (protect_mode_low_in == `SFPI_PMODE_LOW) && !io_s[2];
	// hold and reset share the pin; quad mode disables both
	assign hold_active_out = selected && !quad_ok && !hold_select_in && !hold_pin_raw;
	assign hw_reset_out    = !quad_ok && hold_select_in && !hold_pin_raw;

	// lane width; quad falls back to single unless enabled
	sfpi_lane_t lanes;
	always_comb begin
		lanes = `SFPI_LANE_SINGLE;
		if (lane_mode_in == `SFPI_LANE_DUAL)
			lanes = `SFPI_LANE_DUAL;
		else if (lane_mode_in == `SFPI_LANE_QUAD && lane2_is_data)
			lanes = `SFPI_LANE_QUAD;
	end

	// ----------------------------------------
	// shift engine
	// ----------------------------------------
	logic [7:0] rsh_reg, rsh_next, tsh_reg, tsh_next;
	logic [`SFPI_BITCNT_W-1:0] rcnt_reg, rcnt_next, tcnt_reg, tcnt_next;
	logic [3:0] out_reg, out_next;
	logic drive_reg, drive_next, ovr_reg, ovr_next;
	logic push, f_ready, tx_take;

	// bits per edge for the current lane width
	function automatic logic [`SFPI_BITCNT_W-1:0] step(input sfpi_lane_t l);
		unique case (l)
			`SFPI_LANE_DUAL: step = 3'h2;
			`SFPI_LANE_QUAD: step = 3'h4;
			default:         step = 3'h1;
		endcase
	endfunction

	assign tx_take = sclk_fall && (tcnt_reg == 3'h0) && tx_valid_in;
	assign tx_ready_out = tx_take;

	always_comb begin
		rsh_next   = rsh_reg;
		rcnt_next  = rcnt_reg;
		tsh_next   = tsh_reg;
		tcnt_next  = tcnt_reg;
		out_next   = out_reg;
		drive_next = drive_reg;
		ovr_next   = ovr_reg;
		push       = 1'b0;
		if (!selected) begin
			// deselect aborts partial bytes and releases pins
			rcnt_next  = '0;
			tcnt_next  = '0;
			drive_next = 1'b0;
		end else begin
			if (sclk_rise && !hold_active_out) begin
				unique case (lanes)
					`SFPI_LANE_DUAL: rsh_next = {rsh_reg[5:0], io_s[1:0]};
					`SFPI_LANE_QUAD: rsh_next = {rsh_reg[3:0], io_s};
					default:         rsh_next = {rsh_reg[6:0], io_s[0]};
				endcase
				rcnt_next = rcnt_reg + step(lanes);
				if (rcnt_next == 3'h0) begin
					push = 1'b1;
					if (!f_ready)
						ovr_next = 1'b1;
				end
			end
			if (sclk_fall && !hold_active_out) begin
				if (tx_take) begin
					tsh_next   = tx_data_in;
					drive_next = 1'b1;
				end
				unique case (lanes)
					`SFPI_LANE_DUAL: out_next = {2'b00, tsh_next[7:6]};
					`SFPI_LANE_QUAD: out_next = tsh_next[7:4];
					default:         out_next = {2'b00, tsh_next[7], 1'b0};
				endcase
				if (drive_reg || tx_take) begin
					tsh_next  = tsh_next << step(lanes);
					tcnt_next = tcnt_reg + step(lanes);
				end
			end
		end
	end
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rsh_reg   <= '0;
			rcnt_reg  <= '0;
			tsh_reg   <= '0;
			tcnt_reg  <= '0;
			out_reg   <= '0;
			drive_reg <= 1'b0;
			ovr_reg   <= 1'b0;
		end else begin
			rsh_reg   <= rsh_next;
			rcnt_reg  <= rcnt_next;
			tsh_reg   <= tsh_next;
			tcnt_reg  <= tcnt_next;
			out_reg   <= out_next;
			drive_reg <= drive_next;
			ovr_reg   <= ovr_next;
		end
	end
	assign rx_overrun_out = ovr_reg;
	assign io_out = out_reg;

	// output enables active low; single mode drives serial output only
	always_comb begin
		io_oe_n_out = 4'hf;
		if (selected && drive_reg) begin
			unique case (lanes)
				`SFPI_LANE_DUAL: io_oe_n_out = 4'hc;
				`SFPI_LANE_QUAD: io_oe_n_out = 4'h0;
				default:         io_oe_n_out = 4'hd;
			endcase
		end
	end

	// ----------------------------------------
	// receive fifo
	// ----------------------------------------
	sfpi_fifo #(.WIDTH(`SFPI_BYTE_W), .DEPTH(`SFPI_FIFO_DEPTH), .AW(`SFPI_FIFO_AW)) u_fifo (
		.sys_clk_in   (sys_clk_in),
		.rst_in       (rst_in),
		.wr_valid_in  (push),
		.wr_ready_out (f_ready),
		.wr_data_in   (rsh_next),
		.rd_valid_out (rx_valid_out),
		.rd_ready_in  (rx_ready_in),
		.rd_data_out  (rx_data_out)
	);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_desel_release;
		@(posedge sys_clk_in) disable iff (rst_in) cs_n_s |=> (io_oe_n_out == 4'hf);
	endproperty
	a_desel_release: assert property (p_desel_release) else $error("pins driven while deselected");
	property p_standby;
		@(posedge sys_clk_in) disable iff (rst_in) (cs_n_s && !op_busy_in) [*2] |=> standby_out;
	endproperty
	a_standby: assert property (p_standby) else $error("no standby when idle");
	property p_no_push_desel;
		@(posedge sys_clk_in) disable iff (rst_in) cs_n_s |-> !push;
	endproperty
	a_no_push_desel: assert property (p_no_push_desel) else $error("byte taken while deselected");
	property p_capture;
		@(posedge sys_clk_in) disable iff (rst_in)
			(sclk_rise && !hold_active_out && lanes == `SFPI_LANE_SINGLE) |=> (rsh_reg[0] == $past(io_s[0]));
	endproperty
	a_capture: assert property (p_capture) else $error("input bit not captured");
	property p_launch;
		@(posedge sys_clk_in) disable iff (rst_in) (!sclk_fall) |=> $stable(out_reg);
	endproperty
	a_launch: assert property (p_launch) else $error("output moved off falling edge");
	property p_protect;
		@(posedge sys_clk_in) disable iff (rst_in) quad_lane_enable_in |-> !status_write_block_out;
	endproperty
	a_protect: assert property (p_protect) else $error("protection active in quad mode");
	property p_hold_reset;
		@(posedge sys_clk_in) disable iff (rst_in) !(hold_active_out && hw_reset_out);
	endproperty
	a_hold_reset: assert property (p_hold_reset) else $error("hold and reset both active");
	property p_single_oe;
		@(posedge sys_clk_in) disable iff (rst_in)
			(lanes == `SFPI_LANE_SINGLE) |-> io_oe_n_out[0] && io_oe_n_out[2];
	endproperty
	a_single_oe: assert property (p_single_oe) else $error("serial input driven in single mode");
endmodule

/* verilog/sfpi_defines.svh */
// constants for the serial flash pin interface
`ifndef SFPI_DEFINES_SVH
`define SFPI_DEFINES_SVH
`define SFPI_FIFO_DEPTH   4
`define SFPI_FIFO_AW      2
`define SFPI_BYTE_W       8
`define SFPI_PMODE_HIGH   1'b0
`define SFPI_PMODE_LOW    1'b1
`define SFPI_LANE_SINGLE  2'b00
`define SFPI_LANE_DUAL    2'b01
`define SFPI_LANE_QUAD    2'b10
`define SFPI_BITCNT_W     3
`endif

/* verilog/sfpi_fifo.sv */
// small register-based fifo with valid/ready on both sides
module sfpi_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4,
	parameter int AW    = 2
) (
	// clock and reset
	input  wire logic             sys_clk_in,
	input  wire logic             rst_in,
	// fill side
	input  wire logic             wr_valid_in,
	output logic                  wr_ready_out,
	input  wire logic [WIDTH-1:0] wr_data_in,
	// drain side
	output logic                  rd_valid_out,
	input  wire logic             rd_ready_in,
	output logic [WIDTH-1:0]      rd_data_out
);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wptr_reg, wptr_next, rptr_reg, rptr_next;
	logic [AW:0]      cnt_reg, cnt_next;
	logic [WIDTH-1:0] dout_reg, dout_next;
	logic             push, pop;

	// handshake terms
	assign wr_ready_out = (cnt_reg != (AW+1)'(DEPTH));
	assign rd_valid_out = (cnt_reg != '0);
	assign push = wr_valid_in && wr_ready_out;
	assign pop  = rd_valid_out && rd_ready_in;
	assign rd_data_out = dout_reg;

	// pointer and count update
	always_comb begin
		wptr_next = push ? wptr_reg + AW'(1) : wptr_reg;
		rptr_next = pop ? rptr_reg + AW'(1) : rptr_reg;
		cnt_next  = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
		dout_next = mem_reg[rptr_next];
		if (push && (wptr_reg == rptr_next))
			dout_next = wr_data_in;
	end

	// registers; output word comes from a flop
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			wptr_reg <= '0;
			rptr_reg <= '0;
			cnt_reg  <= '0;
			dout_reg <= '0;
		end else begin
			wptr_reg <= wptr_next;
			rptr_reg <= rptr_next;
			cnt_reg  <= cnt_next;
			dout_reg <= dout_next;
		end
	end

	// storage has no reset, data only
	always_ff @(posedge sys_clk_in) begin
		if (push)
			mem_reg[wptr_reg] <= wr_data_in;
	end
endmodule

/* verilog/sfpi_pkg.sv */
// types for the serial flash pin interface
`include "sfpi_defines.svh"
package sfpi_pkg;
	typedef enum logic [2:0] {
		SFPI_ST_STANDBY = 3'b001,
		SFPI_ST_BUSY    = 3'b010,
		SFPI_ST_ACTIVE  = 3'b100
	} sfpi_state_t;
	typedef logic [1:0] sfpi_lane_t;
endpackage
